// *** ata_cmd_defs.vh ***
// constants for the ata command acceptance block
`ifndef ATA_CMD_DEFS_VH
`define ATA_CMD_DEFS_VH
// task-file offsets
`define OFS_DATA 3'h0
`define OFS_FEATURE 3'h1
`define OFS_SECCNT 3'h2
`define OFS_SECNUM 3'h3
`define OFS_CYLLO 3'h4
`define OFS_CYLHI 3'h5
`define OFS_DRVHD 3'h6
`define OFS_CMD 3'h7
// status, device control and drive/head bits
`define ST_BUSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define DC_NIEN 1
`define DC_SRST 2
`define DH_LBA 6
`define DH_DRV 4
// classes
`define CLS_BAD 2'h0
`define CLS_1 2'h1
`define CLS_2 2'h2
`define CLS_3 2'h3
// timing, at 25 MHz (40 ns), and register reset values
`define CLK_NS 40
`define BUSY_NS 400
`define DRQ2_US 700
`define DRQ3_MS 20
`define BUSY_CYC ((`BUSY_NS) / (`CLK_NS))
`define DRQ2_CYC 20'h0445c
`define DRQ3_CYC 20'h7a120
`define SECCNT_RST 8'h01
`define DRVHD_RST 8'ha0
`define WORK_CYC 20'h00004
// result values
`define SC_SLEEP 8'h00
`define SC_IDLE 8'hff
`define DIAG_OK 8'h01
`define ERR_ABORT 8'h04
`endif

// *** ata_command_acceptance.v ***
// command acceptance and decode logic behind the ata task file
`timescale 1ns/1ps
`include "ata_cmd_defs.vh"
// Overview of operation
// - class 1 sets busy within 400 ns
// - class 2: busy, data request by 700 us
// - class 3: busy, data request by 20 ms
// - decode write codes as class 2
// - write multiple codes are class 3
// - read commands decode as class 1
// - setup and seek codes decode as class 1
// - power codes with alternates are class 1
// - non-standard translate, wear, sense are class 1
// - diagnostic, identify, erase decode as class 1
// - drive-only commands ignore head field
// - check power while sleeping returns 00h
// - check power while idle returns ffh
// - diagnostic result code into error register
// - write without erase behaves as write
// - lba bit selects address layout
// - completion interrupt gated by disable bit
// - error flag set after failed command
module ata_command_acceptance #(
  parameter [19:0] DRQ3_CYCLES = `DRQ3_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // task-file register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire ctl_wr,
  input wire [7:0] ctl_wdata,
  output reg [7:0] reg_rdata_ff,
  // buffer, power and diagnostic state from the card core
  input wire buf_done,
  input wire power_sleep,
  input wire [7:0] diag_code,
  // decoded command to the card core
  output reg cmd_start_ff,
  output reg [7:0] cmd_code_ff,
  output reg [1:0] cmd_class_ff,
  output reg [27:0] cmd_lba_ff,
  output reg cmd_lba_mode_ff,
  output reg cmd_drive_ff,
  output reg [3:0] cmd_head_ff,
  output reg [7:0] cmd_count_ff,
  output reg [7:0] cmd_feature_ff,
  output reg cmd_erase_first_ff,
  // host interrupt and status
  output reg host_irq_ff,
  output reg busy_flag_ff,
  output reg data_request_flag_ff
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_BUSY1 = 3'h1;
  localparam [2:0] S_SETUP = 3'h2;
  localparam [2:0] S_DRQ = 3'h3;
  localparam [2:0] S_DONE = 3'h4;

  reg rst_meta_ff;
  reg rst_sync_ff;
  wire rst_n = rst_sync_ff;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  function [1:0] decode_class;
    input [7:0] c;
    begin
      decode_class = `CLS_BAD;
      case (c)
        8'h50: decode_class = `CLS_2;
        8'he8: decode_class = `CLS_2;
        8'h32, 8'h33: decode_class = `CLS_2;
        8'h30, 8'h31: decode_class = `CLS_2;
        8'h38: decode_class = `CLS_2;
        8'h3c: decode_class = `CLS_2;
        8'hc5: decode_class = `CLS_3;
        8'hcd: decode_class = `CLS_3;
        8'h20, 8'h21: decode_class = `CLS_1;
        8'hc4: decode_class = `CLS_1;
        8'h22, 8'h23: decode_class = `CLS_1;
        8'h40, 8'h41: decode_class = `CLS_1;
        8'he4: decode_class = `CLS_1;
        8'h91: decode_class = `CLS_1;
        8'hef: decode_class = `CLS_1;
        8'hc6: decode_class = `CLS_1;
        8'he5, 8'h98: decode_class = `CLS_1;
        8'he3, 8'h97: decode_class = `CLS_1;
        8'he1, 8'h95: decode_class = `CLS_1;
        8'he6, 8'h99: decode_class = `CLS_1;
        8'he2, 8'h96: decode_class = `CLS_1;
        8'he0, 8'h94: decode_class = `CLS_1;
        8'h87: decode_class = `CLS_1;
        8'hf5: decode_class = `CLS_1;
        8'h03: decode_class = `CLS_1;
        8'h90: decode_class = `CLS_1;
        8'hec: decode_class = `CLS_1;
        8'hc0: decode_class = `CLS_1;
        default: begin
          if (c[7:4] == 4'h1 || c[7:4] == 4'h7)
            decode_class = `CLS_1;
        end
      endcase
    end
  endfunction

  // commands whose drive/head byte carries only the drive bit
  function drive_only;
    input [7:0] c;
    begin
      case (c)
        8'he5, 8'h98: drive_only = 1'b1;
        8'h90: drive_only = 1'b1;
        8'hec: drive_only = 1'b1;
        8'he3, 8'h97: drive_only = 1'b1;
        8'he1, 8'h95: drive_only = 1'b1;
        8'he4: drive_only = 1'b1;
        8'h03: drive_only = 1'b1;
        8'hef: drive_only = 1'b1;
        8'hc6: drive_only = 1'b1;
        8'he6, 8'h99: drive_only = 1'b1;
        8'he2, 8'h96: drive_only = 1'b1;
        8'he0, 8'h94: drive_only = 1'b1;
        8'he8: drive_only = 1'b1;
        default: drive_only = (c[7:4] == 4'h1);
      endcase
    end
  endfunction

  function uses_count;
    input [7:0] c;
    begin
      case (c)
        8'hc0: uses_count = 1'b1;
        8'h50: uses_count = 1'b1;
        8'he3, 8'h97: uses_count = 1'b1;
        8'h91: uses_count = 1'b1;
        8'hc4: uses_count = 1'b1;
        8'h20, 8'h21: uses_count = 1'b1;
        8'h40, 8'h41: uses_count = 1'b1;
        8'hc6: uses_count = 1'b1;
        8'h87: uses_count = 1'b1;
        8'hc5: uses_count = 1'b1;
        8'hcd: uses_count = 1'b1;
        8'h30, 8'h31: uses_count = 1'b1;
        8'h38: uses_count = 1'b1;
        8'h3c: uses_count = 1'b1;
        default: uses_count = 1'b0;
      endcase
    end
  endfunction

  // check power mode, either alternate code
  function check_power;
    input [7:0] c;
    begin
      check_power = (c == 8'he5) || (c == 8'h98);
    end
  endfunction

  // write classes always erase first, even the no-erase codes
  function erase_first;
    input [1:0] k;
    begin
      erase_first = (k == `CLS_2) || (k == `CLS_3);
    end
  endfunction

  reg [7:0] feature_param_ff;
  reg [7:0] sector_count_param_ff;
  reg [7:0] sector_number_param_ff;
  reg [7:0] cylinder_low_param_ff;
  reg [7:0] cylinder_high_param_ff;
  reg [7:0] drive_head_select_ff;
  reg [7:0] error_ff;
  reg err_flag_ff;
  reg interrupt_disable_bit_ff;
  reg srst_ff;
  reg pend_irq_ff;
  reg [2:0] state_ff;
  reg [19:0] cnt_ff;
  reg [7:0] result_sc_ff;
  reg result_sc_ld_ff;

  wire cmd_wr = reg_wr && reg_addr == `OFS_CMD;
  wire status_rd = reg_rd && reg_addr == `OFS_CMD;
  wire [1:0] cls = decode_class(reg_wdata);
  wire [7:0] status = {busy_flag_ff, ~busy_flag_ff, 1'b0, ~busy_flag_ff, data_request_flag_ff, 2'b00, err_flag_ff};

  // device control: disable bit and soft reset
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_disable_bit_ff <= 1'b0;
      srst_ff <= 1'b0;
    end else if (ctl_wr) begin
      interrupt_disable_bit_ff <= ctl_wdata[`DC_NIEN];
      srst_ff <= ctl_wdata[`DC_SRST];
    end
  end

  // parameter registers, writes ignored while busy
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      feature_param_ff <= 8'h00;
      sector_count_param_ff <= `SECCNT_RST;
      sector_number_param_ff <= 8'h01;
      cylinder_low_param_ff <= 8'h00;
      cylinder_high_param_ff <= 8'h00;
      drive_head_select_ff <= `DRVHD_RST;
    end else if (result_sc_ld_ff) begin
      sector_count_param_ff <= result_sc_ff;
    end else if (reg_wr && !busy_flag_ff) begin
      case (reg_addr)
        `OFS_FEATURE: feature_param_ff <= reg_wdata;
        `OFS_SECCNT: sector_count_param_ff <= reg_wdata;
        `OFS_SECNUM: sector_number_param_ff <= reg_wdata;
        `OFS_CYLLO: cylinder_low_param_ff <= reg_wdata;
        `OFS_CYLHI: cylinder_high_param_ff <= reg_wdata;
        `OFS_DRVHD: drive_head_select_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_FEATURE: reg_rdata_ff <= error_ff;
        `OFS_SECCNT: reg_rdata_ff <= sector_count_param_ff;
        `OFS_SECNUM: reg_rdata_ff <= sector_number_param_ff;
        `OFS_CYLLO: reg_rdata_ff <= cylinder_low_param_ff;
        `OFS_CYLHI: reg_rdata_ff <= cylinder_high_param_ff;
        `OFS_DRVHD: reg_rdata_ff <= drive_head_select_ff;
        `OFS_CMD: reg_rdata_ff <= status;
        default: reg_rdata_ff <= 8'h00;
      endcase
    end
  end

  // acceptance sequencer
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      cnt_ff <= 20'h00000;
      busy_flag_ff <= 1'b0;
      data_request_flag_ff <= 1'b0;
      err_flag_ff <= 1'b0;
      error_ff <= `DIAG_OK;
      pend_irq_ff <= 1'b0;
      host_irq_ff <= 1'b0;
      cmd_start_ff <= 1'b0;
      cmd_code_ff <= 8'h00;
      cmd_class_ff <= `CLS_BAD;
      cmd_lba_ff <= 28'h0000000;
      cmd_lba_mode_ff <= 1'b0;
      cmd_drive_ff <= 1'b0;
      cmd_head_ff <= 4'h0;
      cmd_count_ff <= 8'h00;
      cmd_feature_ff <= 8'h00;
      cmd_erase_first_ff <= 1'b0;
      result_sc_ff <= 8'h00;
      result_sc_ld_ff <= 1'b0;
    end else begin
      cmd_start_ff <= 1'b0;
      pend_irq_ff <= 1'b0;
      result_sc_ld_ff <= 1'b0;
      host_irq_ff <= (pend_irq_ff || (host_irq_ff && !status_rd)) && !interrupt_disable_bit_ff;
      if (srst_ff) begin
        state_ff <= S_IDLE;
        busy_flag_ff <= 1'b0;
        data_request_flag_ff <= 1'b0;
        host_irq_ff <= 1'b0;
      end else begin
        case (state_ff)
          S_IDLE: begin
            if (cmd_wr && !busy_flag_ff) begin
              cmd_code_ff <= reg_wdata;
              cmd_class_ff <= cls;
              cmd_feature_ff <= feature_param_ff;
              cmd_count_ff <= uses_count(reg_wdata) ? sector_count_param_ff : 8'h00;
              cmd_drive_ff <= drive_head_select_ff[`DH_DRV];
              cmd_head_ff <= drive_only(reg_wdata) ? 4'h0 : drive_head_select_ff[3:0];
              cmd_lba_mode_ff <= drive_head_select_ff[`DH_LBA];
              cmd_lba_ff <= {drive_head_select_ff[3:0], cylinder_high_param_ff,
                             cylinder_low_param_ff, sector_number_param_ff};
              cmd_erase_first_ff <= erase_first(cls);
              cnt_ff <= 20'h00000;
              data_request_flag_ff <= 1'b0;
              if (cls == `CLS_BAD) begin
                err_flag_ff <= 1'b1;
                error_ff <= `ERR_ABORT;
                pend_irq_ff <= 1'b1;
              end else begin
                busy_flag_ff <= 1'b1;
                err_flag_ff <= 1'b0;
                cmd_start_ff <= 1'b1;
                state_ff <= (cls == `CLS_1) ? S_BUSY1 : S_SETUP;
              end
            end
          end
          S_BUSY1: begin
            cnt_ff <= cnt_ff + 20'h00001;
            if (cnt_ff == `WORK_CYC) begin
              if (check_power(cmd_code_ff)) begin
                result_sc_ff <= power_sleep ? `SC_SLEEP : `SC_IDLE;
                result_sc_ld_ff <= 1'b1;
              end
              if (cmd_code_ff == 8'h90)
                error_ff <= diag_code;
              state_ff <= S_DONE;
            end
          end
          S_SETUP: begin
            cnt_ff <= cnt_ff + 20'h00001;
            if (buf_done || cnt_ff == (((cmd_class_ff == `CLS_2) ? `DRQ2_CYC : DRQ3_CYCLES) - 20'h00001)) begin
              data_request_flag_ff <= 1'b1;
              state_ff <= S_DRQ;
            end
          end
          S_DRQ: begin
            busy_flag_ff <= 1'b0;
            state_ff <= S_IDLE;
          end
          S_DONE: begin
            busy_flag_ff <= 1'b0;
            pend_irq_ff <= 1'b1;
            state_ff <= S_IDLE;
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// *** ata_cmd_monitor.sv ***
// assertion checker for the command acceptance block
`timescale 1ns/1ps
`include "ata_cmd_defs.vh"
module ata_cmd_monitor #(
  parameter [19:0] DRQ3_CYCLES = `DRQ3_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // host side
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire ctl_wr,
  input wire [7:0] ctl_wdata,
  // command and status
  input wire cmd_start_ff,
  input wire [1:0] cmd_class_ff,
  input wire host_irq_ff,
  input wire busy_flag_ff,
  input wire data_request_flag_ff
);
  reg nien_ff;
  reg [19:0] wait_ff;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nien_ff <= 1'b0;
      wait_ff <= 20'h0;
    end else begin
      if (ctl_wr) nien_ff <= ctl_wdata[1];
      wait_ff <= (busy_flag_ff && !data_request_flag_ff) ? wait_ff + 20'h1 : 20'h0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_start_cause: assert property (cmd_start_ff |-> $past(reg_wr) && $past(reg_addr) == 3'h7 && !$past(busy_flag_ff))
    else $error("start without command write");
  a_busy_refuse: assert property (busy_flag_ff && reg_wr && reg_addr == 3'h7 |=> !cmd_start_ff)
    else $error("command taken while busy");
  a_busy_set: assert property (cmd_start_ff |-> busy_flag_ff)
    else $error("busy missing after command");
  a_class1_done: assert property (cmd_start_ff && cmd_class_ff == `CLS_1 |-> ##[1:12] !busy_flag_ff)
    else $error("class 1 busy too long");
  a_drop_after_drq: assert property ($rose(data_request_flag_ff) |-> ##[0:10] !busy_flag_ff)
    else $error("busy not cleared after data request");
  a_wait_cls2: assert property (busy_flag_ff && cmd_class_ff == `CLS_2 |-> wait_ff <= 20'd17502)
    else $error("class 2 data request late");
  a_wait_cls3: assert property (busy_flag_ff && cmd_class_ff == `CLS_3 |-> wait_ff <= DRQ3_CYCLES + 20'd2)
    else $error("class 3 data request late");
  a_irq_gated: assert property (host_irq_ff |-> !nien_ff)
    else $error("interrupt while disabled");
  a_class_stable: assert property (busy_flag_ff && $past(busy_flag_ff) |-> $stable(cmd_class_ff))
    else $error("class changed while busy");
endmodule
bind ata_command_acceptance ata_cmd_monitor #(.DRQ3_CYCLES(DRQ3_CYCLES)) mon (.clk_sys(clk_sys), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .cmd_start_ff(cmd_start_ff),
  .cmd_class_ff(cmd_class_ff), .host_irq_ff(host_irq_ff), .busy_flag_ff(busy_flag_ff),
  .data_request_flag_ff(data_request_flag_ff));

// *** ata_host_model.sv ***
// host task-file driver model
`timescale 1ns/1ps
module ata_host_model (
  // clock
  input wire clk_sys,
  // status from the card
  input wire busy_flag_ff,
  input wire [7:0] reg_rdata_ff,
  // task-file strobes
  output logic [2:0] reg_addr = 3'h0,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic ctl_wr = 1'b0,
  output logic [7:0] ctl_wdata = 8'h00
);
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata_ff;
  endtask
  task automatic ctl(input logic [7:0] d);
    @(posedge clk_sys);
    ctl_wdata <= d;
    ctl_wr <= 1'b1;
    @(posedge clk_sys);
    ctl_wr <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    int i;
    for (i = 0; i < 3000 && busy_flag_ff !== 1'b0; i++) @(posedge clk_sys);
    wr(3'h7, c);
  endtask
endmodule

// *** testbench.sv ***
// self-checking testbench for the command acceptance block
`timescale 1ns/1ps
`include "ata_cmd_defs.vh"
module testbench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic buf_done = 1'b0;
  logic power_sleep = 1'b0;
  logic [7:0] diag_code = 8'h01;
  logic irq_en = 1'b1;
  logic [7:0] d;
  logic [263:0] c1 = 264'h2021c42223_4041e491efc6_e598e397e195_e699e296e094_87f503_90ecc0_107f1a70;
  logic [63:0] c2 = 64'h50e832333031383c;
  logic [15:0] c3 = 16'hc5cd;
  wire [2:0] reg_addr;
  wire [7:0] reg_wdata, ctl_wdata, reg_rdata_ff, cmd_count_ff, cmd_code_ff, cmd_feature_ff;
  wire cmd_erase_first_ff;
  wire reg_wr, reg_rd, ctl_wr, cmd_start_ff, cmd_lba_mode_ff, cmd_drive_ff, host_irq_ff;
  wire busy_flag_ff, data_request_flag_ff;
  wire [1:0] cmd_class_ff;
  wire [27:0] cmd_lba_ff;
  wire [3:0] cmd_head_ff;
  integer n_fail = 0;
  integer total_checks = 0;
  ata_host_model host (.clk_sys(clk_sys), .busy_flag_ff(busy_flag_ff), .reg_rdata_ff(reg_rdata_ff),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata));
  ata_command_acceptance #(.DRQ3_CYCLES(20'd50)) uut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .reg_rdata_ff(reg_rdata_ff), .buf_done(buf_done), .power_sleep(power_sleep), .diag_code(diag_code),
    .cmd_start_ff(cmd_start_ff), .cmd_code_ff(cmd_code_ff), .cmd_class_ff(cmd_class_ff), .cmd_lba_ff(cmd_lba_ff),
    .cmd_lba_mode_ff(cmd_lba_mode_ff), .cmd_drive_ff(cmd_drive_ff), .cmd_head_ff(cmd_head_ff),
    .cmd_count_ff(cmd_count_ff), .cmd_feature_ff(cmd_feature_ff), .cmd_erase_first_ff(cmd_erase_first_ff),
    .host_irq_ff(host_irq_ff),
    .busy_flag_ff(busy_flag_ff), .data_request_flag_ff(data_request_flag_ff));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 200 && busy_flag_ff !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("busy end", 1'b0, busy_flag_ff);
  endtask
  task issue(input logic [7:0] c, input logic [1:0] cls);
    host.cmd(c);
    #1;
    chk("start", 1'b1, cmd_start_ff);
    chk("class", cls, cmd_class_ff);
    chk("code", c, cmd_code_ff);
    chk("erase", cls != `CLS_1, cmd_erase_first_ff);
    wait_idle;
    if (cls != `CLS_1) chk("drq", 1'b1, data_request_flag_ff);
    @(posedge clk_sys);
    #1;
    if (cls == `CLS_1) chk("irq", irq_en, host_irq_ff);
    host.rd(3'h7, d);
  endtask
  task t_classes;
    int i;
    for (i = 0; i < 33; i++) issue(c1[8*i+:8], `CLS_1);
    buf_done <= 1'b1;
    for (i = 0; i < 8; i++) issue(c2[8*i+:8], `CLS_2);
    buf_done <= 1'b0;
    for (i = 0; i < 2; i++) issue(c3[8*i+:8], `CLS_3);
    $display("test classes done");
  endtask
  task t_results;
    power_sleep <= 1'b1;
    issue(8'he5, `CLS_1);
    host.rd(3'h2, d);
    chk("sleep count", 8'h00, d);
    power_sleep <= 1'b0;
    issue(8'h98, `CLS_1);
    host.rd(3'h2, d);
    chk("idle count", 8'hff, d);
    diag_code <= 8'h85;
    issue(8'h90, `CLS_1);
    host.rd(3'h1, d);
    chk("diag", 8'h85, d);
    host.cmd(8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("abort irq", 1'b1, host_irq_ff);
    chk("abort busy", 1'b0, busy_flag_ff);
    host.rd(3'h7, d);
    chk("err flag", 1'b1, d[0]);
    host.rd(3'h1, d);
    chk("abort code", 8'h04, d);
    $display("test results done");
  endtask
  task t_params;
    host.wr(3'h6, 8'he5);
    host.wr(3'h5, 8'h12);
    host.wr(3'h4, 8'h34);
    host.wr(3'h3, 8'h56);
    host.wr(3'h2, 8'h02);
    host.cmd(8'h20);
    host.wr(3'h3, 8'h99);
    #1;
    chk("lba", 28'h5123456, cmd_lba_ff);
    chk("lba mode", 1'b1, cmd_lba_mode_ff);
    chk("count", 8'h02, cmd_count_ff);
    wait_idle;
    host.wr(3'h6, 8'hbf);
    issue(8'he4, `CLS_1);
    chk("head", 4'h0, cmd_head_ff);
    chk("drive", 1'b1, cmd_drive_ff);
    host.wr(3'h1, 8'h5a);
    issue(8'hef, `CLS_1);
    chk("feature", 8'h5a, cmd_feature_ff);
    host.ctl(8'h02);
    irq_en = 1'b0;
    issue(8'he1, `CLS_1);
    host.ctl(8'h00);
    $display("test params done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    results;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_classes;
    t_results;
    t_params;
    results;
  end
endmodule
